//--- design/hbs_fault_flags.sv
// Sticky per-switch fault flags with clear-on-read.
// Assumes set and clear come from the same clock domain, already synchronised.
module hbs_fault_flags
  import hbs_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic soft_rst_i,
  input wire hbs_fault_s set_i,
  input wire hbs_fault_s clr_i,
  output hbs_fault_s flags_o
);

  hbs_fault_s flags_q, flags_d;

  always_comb begin
    if (soft_rst_i) begin
      flags_d = '0;
    end else begin
      // A detection in the clearing cycle survives the read
      flags_d = (flags_q & ~clr_i) | set_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign flags_o = flags_q;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  chk_set_beats_clear: assert property (
    !soft_rst_i && (set_i.ot != '0) |=> ((flags_q.ot & $past(set_i.ot)) == $past(set_i.ot)))
    else $error("overtemperature event lost");

  chk_read_clears_flag: assert property (
    !soft_rst_i && (clr_i.oc != '0) && (set_i.oc == '0) |=> ((flags_q.oc & $past(clr_i.oc)) == '0))
    else $error("overcurrent flag not cleared");

  chk_openload_sticky: assert property (
    !soft_rst_i && (clr_i.ol == '0) |=> ((flags_q.ol & $past(flags_q.ol)) == $past(flags_q.ol)))
    else $error("open-load flag dropped without read");

  chk_soft_zero: assert property (
    soft_rst_i |=> (flags_q == '0))
    else $error("flags not zero after soft reset");

endmodule

//--- design/hbs_status_regs.sv
// Read-only status bank: high-side fault flags and bridge general status.
// Assumes the serial core issues one-cycle reads; detectors and pins are asynchronous.
`include "hbs_params.svh"

module hbs_status_regs
  import hbs_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic soft_rst_i,
  input wire logic restart_i,
  input wire hbs_rd_req_s rd_req_i,
  input wire hbs_fault_s fault_det_i,
  input wire hbs_bridge_s bridge_ctrl_i,
  input wire logic [`HBS_CH_N-1:0] bridge_vds_low_i,
  input wire logic [`HBS_CH_N-1:0] pwm_pin_i,
  output logic [`HBS_DATA_W-1:0] rd_data_o,
  output logic rd_valid_o
);

  localparam int FW = $bits(hbs_fault_s);

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisation
  hbs_fault_s fault_sync;
  logic [`HBS_CH_N-1:0] vds_sync;
  logic [`HBS_CH_N-1:0] pwm_sync;

  hbs_sync3 #(.WIDTH(FW)) u_sync_fault (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(fault_det_i),
    .sync_o(fault_sync)
  );

  hbs_sync3 #(.WIDTH(2 * `HBS_CH_N)) u_sync_pins (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i({bridge_vds_low_i, pwm_pin_i}),
    .sync_o({vds_sync, pwm_sync})
  );

  ////////////////////////////////////////////////////////////////////////
  // Fault flags, cleared by a read of their register
  logic fault_rd;
  hbs_fault_s fault_clr;
  hbs_fault_s flags;

  assign fault_rd = rd_req_i.en && (rd_req_i.addr == `HBS_ADDR_FAULT);
  // Only bits seen by this read are cleared; restart holds them
  assign fault_clr = (fault_rd && !restart_i) ? flags : '0;

  hbs_fault_flags u_flags (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .soft_rst_i(soft_rst_i),
    .set_i(fault_sync),
    .clr_i(fault_clr),
    .flags_o(flags)
  );

  ////////////////////////////////////////////////////////////////////////
  // General status: live levels, snapshot each cycle
  logic [`HBS_DATA_W-1:0] gen_q, gen_d;
  logic [`HBS_CH_N-1:0] vout;

  always_comb begin
    for (int i = 0; i < `HBS_CH_N; i++) begin
      vout[i] = bridge_ctrl_i.cp_en && (bridge_ctrl_i.mode[i] == `HBS_MODE_DRIVE)
                && vds_sync[i];
    end
    if (soft_rst_i) begin
      gen_d = `HBS_REG_RESET;
    end else if (restart_i) begin
      gen_d = gen_q & `HBS_GEN_RESTART_KEEP;
    end else begin
      gen_d = `HBS_REG_RESET;
      gen_d[`HBS_VOUT_LSB +: `HBS_CH_N] = vout;
      gen_d[`HBS_PWM_LSB +: `HBS_CH_N] = pwm_sync;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      gen_q <= `HBS_REG_RESET;
    end else begin
      gen_q <= gen_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port: data one cycle after the request, unmapped reads return zero
  logic [`HBS_DATA_W-1:0] rd_data_q, rd_data_d;
  logic rd_valid_q, rd_valid_d;

  always_comb begin
    rd_valid_d = rd_req_i.en;
    rd_data_d = `HBS_REG_RESET;
    if (rd_req_i.en) begin
      case (rd_req_i.addr)
        `HBS_ADDR_FAULT: rd_data_d = hbs_fault_word(flags) & `HBS_FAULT_MASK;
        `HBS_ADDR_GEN: rd_data_d = gen_q & `HBS_GEN_MASK;
        default: rd_data_d = `HBS_REG_RESET;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rd_data_q <= `HBS_REG_RESET;
      rd_valid_q <= 1'b0;
    end else begin
      rd_data_q <= rd_data_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  assign rd_data_o = rd_data_q;
  assign rd_valid_o = rd_valid_q;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  chk_fault_reserved_zero: assert property (
    rd_valid_o && $past(rd_req_i.addr) == `HBS_ADDR_FAULT |->
      (rd_data_o & ~`HBS_FAULT_MASK) == '0)
    else $error("fault register reserved bits not zero");

  chk_gen_reserved_zero: assert property (
    rd_valid_o |-> (gen_q & ~`HBS_GEN_MASK) == '0)
    else $error("general status reserved bits set");

  chk_vout_needs_pump: assert property (
    !soft_rst_i && !restart_i && !bridge_ctrl_i.cp_en |=> gen_q[`HBS_VOUT_LSB +: `HBS_CH_N] == '0)
    else $error("bridge level set with pump off");

  chk_vout_follows: assert property (
    !soft_rst_i && !restart_i && bridge_ctrl_i.cp_en
      && bridge_ctrl_i.mode[0] == `HBS_MODE_DRIVE |=> gen_q[`HBS_VOUT_LSB] == $past(vds_sync[0]))
    else $error("bridge one level wrong");

  chk_pwm_reflect: assert property (
    !soft_rst_i && !restart_i |=> gen_q[`HBS_PWM_LSB +: `HBS_CH_N] == $past(pwm_sync))
    else $error("pwm level not reflected");

  chk_restart_keep: assert property (
    restart_i && !soft_rst_i |=> gen_q == ($past(gen_q) & `HBS_GEN_RESTART_KEEP))
    else $error("general status restart value wrong");

  chk_restart_hold_flags: assert property (
    restart_i && !soft_rst_i |=> (flags & $past(flags)) == $past(flags))
    else $error("fault flags lost on restart");

  chk_read_then_zero: assert property (
    fault_rd && !restart_i && !soft_rst_i && fault_sync == '0 ##1 rd_req_i.en
      && rd_req_i.addr == `HBS_ADDR_FAULT && fault_sync == '0 |=> rd_data_o == '0)
    else $error("second fault read not cleared");

  chk_soft_reset_zero: assert property (
    soft_rst_i ##1 rd_req_i.en |=> rd_data_o == '0)
    else $error("register nonzero after soft reset");

endmodule

//--- design/hbs_sync3.sv
// Three-stage synchroniser for pin and analog comparator levels.
// Assumes inputs are asynchronous to clk_i; output changes once stages 2 and 3 agree.
module hbs_sync3 #(
  parameter int WIDTH = 4
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] s1_q, s2_q, s3_q, out_q;
  logic [WIDTH-1:0] s1_d, s2_d, s3_d, out_d;

  always_comb begin
    s1_d = async_i;
    s2_d = s1_q;
    s3_d = s2_q;
    // Agreement filter hides a single metastable resolution
    for (int i = 0; i < WIDTH; i++) begin
      out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      out_q <= out_d;
    end
  end

  assign sync_o = out_q;

endmodule

//--- shared/hbs_params.svh
// Constants for the high-side fault and bridge general status registers.
// Assumes a 10 MHz clk_i and a register read port fed by the serial core.
`ifndef HBS_PARAMS_SVH
`define HBS_PARAMS_SVH

`define HBS_ADDR_W 7
`define HBS_DATA_W 16
`define HBS_CH_N 4
`define HBS_ADDR_FAULT 7'h46
`define HBS_ADDR_GEN 7'h50
`define HBS_REG_RESET 16'h0000
`define HBS_OT_LSB 10
`define HBS_OL_LSB 5
`define HBS_OC_LSB 0
`define HBS_VOUT_LSB 6
`define HBS_PWM_LSB 0
`define HBS_MODE_DRIVE 2'h3
`define HBS_FAULT_MASK 16'h3DEF
`define HBS_GEN_MASK 16'h03CF
`define HBS_FAULT_RESTART_KEEP 16'h3FFF
`define HBS_GEN_RESTART_KEEP 16'h00C1

`endif

//--- shared/hbs_pkg.sv
// Types shared by the status register bank and its helpers.
// Assumes hbs_params.svh is on the include path.
`include "hbs_params.svh"

package hbs_pkg;

  typedef logic [`HBS_CH_N-1:0] hbs_ch_t;

  typedef struct packed {
    hbs_ch_t ot;
    hbs_ch_t ol;
    hbs_ch_t oc;
  } hbs_fault_s;

  typedef struct packed {
    logic en;
    logic [`HBS_ADDR_W-1:0] addr;
  } hbs_rd_req_s;

  typedef struct packed {
    logic cp_en;
    logic [`HBS_CH_N-1:0][1:0] mode;
  } hbs_bridge_s;

  // Places the three flag groups at their bit fields
  function automatic logic [`HBS_DATA_W-1:0] hbs_fault_word(hbs_fault_s f);
    logic [`HBS_DATA_W-1:0] w;
    w = `HBS_REG_RESET;
    w[`HBS_OT_LSB +: `HBS_CH_N] = f.ot;
    w[`HBS_OL_LSB +: `HBS_CH_N] = f.ol;
    w[`HBS_OC_LSB +: `HBS_CH_N] = f.oc;
    return w;
  endfunction

endpackage

//--- sim/hbs_host_model.sv
// Host side of the status read port: issues one register read at a time.
// Assumes a single clock and the one-cycle read answer of the status bank.
`include "hbs_params.svh"

module hbs_host_model
  import hbs_pkg::*;
(
  input wire logic clk_i,
  input wire logic [`HBS_DATA_W-1:0] rd_data_i,
  input wire logic rd_valid_i,
  output hbs_rd_req_s rd_req_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial rd_req_o = '0;

  // Address is scrambled once released so a stale value is never trusted
  task automatic read(input logic [`HBS_ADDR_W-1:0] addr, output logic [`HBS_DATA_W-1:0] data,
                      output logic vld);
    @(posedge clk_i);
    #1;
    rd_req_o.en = 1'b1;
    rd_req_o.addr = addr;
    // Answer is registered by the taking edge and stands for one cycle only
    @(posedge clk_i);
    #1;
    rd_req_o.en = 1'b0;
    rd_req_o.addr = ~addr;
    data = rd_data_i;
    vld = rd_valid_i;
  endtask

  // Two reads on consecutive edges; the request stands through both
  task automatic read_pair(input logic [`HBS_ADDR_W-1:0] addr,
                           output logic [`HBS_DATA_W-1:0] data0,
                           output logic [`HBS_DATA_W-1:0] data1);
    @(posedge clk_i);
    #1;
    rd_req_o.en = 1'b1;
    rd_req_o.addr = addr;
    @(posedge clk_i);
    #1;
    data0 = rd_data_i;
    @(posedge clk_i);
    #1;
    rd_req_o.en = 1'b0;
    rd_req_o.addr = ~addr;
    data1 = rd_data_i;
  endtask
endmodule

//--- sim/tb.sv
// Self-checking bench for the status register bank.
// Assumes the host model drives reads; expectations come from an integer model.
`include "hbs_params.svh"

module tb
  import hbs_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;

  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic soft_rst_i = 1'b0;
  logic restart_i = 1'b0;
  hbs_rd_req_s rd_req;
  hbs_fault_s fault_det = '0;
  hbs_bridge_s bridge_ctrl = '0;
  logic [3:0] vds_low = 4'h0;
  logic [3:0] pwm_pin = 4'h0;
  logic [15:0] rd_data;
  logic [15:0] got;
  logic [15:0] got2;
  logic rd_valid;
  logic vld;
  int errors = 0;
  int checks = 0;
  int flags = 0;

  hbs_status_regs hbs_status_regs_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .soft_rst_i(soft_rst_i), .restart_i(restart_i), .rd_req_i(rd_req),
    .fault_det_i(fault_det), .bridge_ctrl_i(bridge_ctrl), .bridge_vds_low_i(vds_low),
    .pwm_pin_i(pwm_pin), .rd_data_o(rd_data), .rd_valid_o(rd_valid));
  hbs_host_model hbs_host_model_inst (.clk_i(clk_i), .rd_data_i(rd_data),
    .rd_valid_i(rd_valid), .rd_req_o(rd_req));

  initial forever #50 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rd(input logic [6:0] a);
    hbs_host_model_inst.read(a, got, vld);
    check("valid", {15'h0000, vld}, 16'h0001);
  endtask

  // Detector held long enough to cross the synchroniser, then dropped
  task automatic fault(input logic [11:0] v);
    @(posedge clk_i);
    #1;
    fault_det = v;
    repeat (6) @(posedge clk_i);
    #1;
    fault_det = '0;
    repeat (6) @(posedge clk_i);
    flags = flags | (int'(v[11:8]) << 10) | (int'(v[7:4]) << 5) | int'(v[3:0]);
  endtask

  function automatic logic [15:0] gen_exp();
    int e;
    e = int'(pwm_pin);
    for (int i = 0; i < 4; i++) begin
      if (bridge_ctrl.cp_en && bridge_ctrl.mode[i] == 2'h3 && vds_low[i]) e |= 1 << (6 + i);
    end
    return e[15:0];
  endfunction

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(99098));
    repeat (2) @(posedge clk_i);
    #1;
    sys_rst_i = 1'b0;
    rd(`HBS_ADDR_FAULT);
    check("fault", got, 16'h0000);
    rd(`HBS_ADDR_GEN);
    check("gen", got, 16'h0000);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      fault(12'($urandom));
      rd(`HBS_ADDR_FAULT);
      check("fault", got, flags[15:0]);
      flags = 0;
      rd(`HBS_ADDR_FAULT);
      check("fault cleared", got, 16'h0000);
    end
    // Back-to-back reads: the second sees the clear of the first
    fault(12'($urandom));
    hbs_host_model_inst.read_pair(`HBS_ADDR_FAULT, got, got2);
    check("fault pair first", got, flags[15:0]);
    check("fault pair second", got2, 16'h0000);
    flags = 0;
    $display("test fault flags done");
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_i);
      #1;
      bridge_ctrl = 9'($urandom);
      bridge_ctrl.cp_en = i[0];
      // Last pass forces every bridge into the drive mode with the pump on
      if (i == 7) bridge_ctrl.mode = '1;
      vds_low = 4'($urandom);
      pwm_pin = 4'($urandom);
      repeat (6) @(posedge clk_i);
      rd(`HBS_ADDR_GEN);
      check("gen", got, gen_exp());
    end
    $display("test general status done");
    fault(12'hFFF);
    @(posedge clk_i);
    #1;
    restart_i = 1'b1;
    // Restart held through two reads: bits 7, 6, 0 kept, reads do not clear
    rd(`HBS_ADDR_GEN);
    check("gen during restart", got, gen_exp() & 16'h00C1);
    rd(`HBS_ADDR_FAULT);
    check("fault during restart", got, flags[15:0]);
    restart_i = 1'b0;
    rd(`HBS_ADDR_FAULT);
    check("fault after restart", got, flags[15:0]);
    flags = 0;
    rd(`HBS_ADDR_GEN);
    check("gen after restart", got, gen_exp());
    $display("test restart done");
    fault(12'h5A5);
    @(posedge clk_i);
    #1;
    soft_rst_i = 1'b1;
    flags = 0;
    rd(`HBS_ADDR_FAULT);
    check("fault soft reset", got, 16'h0000);
    rd(`HBS_ADDR_GEN);
    check("gen soft reset", got, 16'h0000);
    soft_rst_i = 1'b0;
    $display("test soft reset done");
    rd(7'h47);
    check("unmapped", got, 16'h0000);
    $display("test unmapped done");
    give_verdict();
  end

  // Whole run is a few hundred cycles; this margin only cuts a hang
  initial begin
    #(100 * 5000);
    errors++;
    give_verdict();
  end
endmodule
